// ### rtl/vfgc_pkg.sv
/*
  Shared constants and types for the video frame grabber controller.
  Assumes one system clock, one video sample per clock, APB register access.
*/
package vfgc_pkg;
  localparam int SAMPLE_W = 8;
  localparam int ADDR_W = 18;
  localparam int ADDR_STAGE_W = 9;
  localparam int SYNC_W = 7;
  localparam int SYNC_LO_W = 4;
  localparam logic [SYNC_W-1:0] SYNC_FULL = 7'h7f;
  localparam int FRAME_SAMPLES_DEF = 32'h0003dd3d;
  localparam int FRAMES_W = 16;
  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [PADDR_W-1:0] REG_ADDR = 8'h08;
  localparam logic [PADDR_W-1:0] REG_FRAMES = 8'h0c;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RST = 1'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_VSYNC_BIT = 2;
  localparam int STAT_BUTTON_BIT = 3;
  localparam int STAT_WE_BIT = 4;
  localparam int STAT_OE_BIT = 5;
  typedef enum logic [1:0] {
    VFGC_PASS = 2'b00,
    VFGC_WAIT_VS = 2'b01,
    VFGC_SAMPLE = 2'b10,
    VFGC_REPLAY = 2'b11
  } vfgc_state_t;
endpackage

// ### rtl/vfgc_link_if.sv
/*
  Internal link between the controller, the sync detector and the
  address counter. Assumes all three run on the same system clock.
*/
`timescale 1ns/1ps
interface vfgc_link_if;
  logic [vfgc_pkg::SAMPLE_W-1:0] sample;
  logic count_enable;
  logic [vfgc_pkg::ADDR_W-1:0] addr;
  logic frame_end;
  logic vsync;
  logic [vfgc_pkg::SYNC_W-1:0] sync_count;
  modport ctl (output sample, output count_enable, input addr,
    input frame_end, input vsync, input sync_count);
  modport sync (input sample, output vsync, output sync_count);
  modport ctr (input count_enable, output addr, output frame_end);
endinterface

// ### rtl/vfgc_sync_det.sv
/*
  Zero-run vertical sync detector, 7-bit counter in two stages.
  Assumes samples arrive already synchronised to mclk.
*/
`timescale 1ns/1ps
module vfgc_sync_det (
  input wire logic mclk,
  input wire logic rstn,
  vfgc_link_if.sync link
);
  localparam int HI_W = vfgc_pkg::SYNC_W - vfgc_pkg::SYNC_LO_W;
  logic [vfgc_pkg::SYNC_LO_W-1:0] cnt_lo;
  logic [HI_W-1:0] cnt_hi;
  wire is_zero = (link.sample == '0);
  wire lo_carry = &cnt_lo;

  always_ff @(posedge mclk) begin
    if (!rstn || !is_zero) begin
      cnt_lo <= '0;
      cnt_hi <= '0;
    end else begin
      cnt_lo <= cnt_lo + 1'b1;
      if (lo_carry) begin
        cnt_hi <= cnt_hi + 1'b1;
      end
    end
  end

  assign link.sync_count = {cnt_hi, cnt_lo};
  assign link.vsync = (link.sync_count == vfgc_pkg::SYNC_FULL);

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_sync_count_up: assert property (
    is_zero |=> link.sync_count == $past(link.sync_count) + 7'h01)
    else $error("sync count did not advance on zero sample");
  a_sync_nonzero_clr: assert property (
    !is_zero |=> link.sync_count == 7'h00)
    else $error("sync count not cleared by nonzero sample");
  a_vsync_after_run: assert property (
    link.sync_count == 7'h7e && is_zero |=> link.vsync)
    else $error("vsync missing at full zero run");
endmodule

// ### rtl/vfgc_addr_ctr.sv
/*
  Frame RAM address counter, two cascaded stages, clears at frame end.
  Assumes the controller holds count_enable for capture and replay.
*/
`timescale 1ns/1ps
module vfgc_addr_ctr #(
  parameter int FRAME_SAMPLES = vfgc_pkg::FRAME_SAMPLES_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  vfgc_link_if.ctr link
);
  localparam int SW = vfgc_pkg::ADDR_STAGE_W;
  localparam logic [vfgc_pkg::ADDR_W-1:0] LAST =
    vfgc_pkg::ADDR_W'(FRAME_SAMPLES - 1);

  if (FRAME_SAMPLES < 2 || FRAME_SAMPLES > 2 ** vfgc_pkg::ADDR_W ||
      2 * SW != vfgc_pkg::ADDR_W) begin : g_bad_len
    $error("frame length does not fit the address counter");
  end

  logic [SW-1:0] cnt_lo;
  logic [SW-1:0] cnt_hi;
  wire lo_carry = &cnt_lo;
  wire at_last = ({cnt_hi, cnt_lo} == LAST);
  wire clear = !link.count_enable || at_last;

  always_ff @(posedge mclk) begin
    if (!rstn || clear) begin
      cnt_lo <= '0;
      cnt_hi <= '0;
    end else begin
      cnt_lo <= cnt_lo + 1'b1;
      if (lo_carry) begin
        cnt_hi <= cnt_hi + 1'b1;
      end
    end
  end

  assign link.addr = {cnt_hi, cnt_lo};
  assign link.frame_end = link.count_enable && at_last;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_addr_step: assert property (
    link.count_enable && !at_last |=> link.addr == $past(link.addr) + 18'h1)
    else $error("address did not advance");
  a_addr_idle_zero: assert property (
    !link.count_enable |=> link.addr == 18'h0)
    else $error("address not cleared while disabled");
  a_addr_wrap: assert property (
    link.frame_end |=> link.addr == 18'h0)
    else $error("address did not wrap at final sample");
endmodule

// ### rtl/vfgc_top.sv
/*
  Video frame grabber controller: sync detection, capture state machine,
  frame RAM addressing and control, APB status and control registers.
  Assumes the converter, RAM and output buffers share mclk; the RAM data
  bus runs outside this block; button and video pins are asynchronous.
*/
// What this block does
// - Take one 8-bit sample every clock
// - Replay one RAM address per clock
// - Sync counter counts consecutive zero samples
// - Nonzero sample clears the sync counter
// - Count of 127 raises vsync_detected
// - Sync counter built as two carried stages
// - Button held keeps live pass-through
// - On release, wait for vsync before storing
// - Store exactly 253245 consecutive samples
// - Write enable high through whole sampling
// - At final count stop writing, start reading
// - Replay frame forever until button pressed
// - Drive 18-bit address and RAM controls
// - RAM drives bus only when reading
// - Converter buffer on except during replay
// - Address counts when enabled, else clears
// - Address counter as two 9-bit stages
`timescale 1ns/1ps
module vfgc_top #(
  parameter int FRAME_SAMPLES = vfgc_pkg::FRAME_SAMPLES_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [vfgc_pkg::SAMPLE_W-1:0] video_sample,
  input wire logic capture_button,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vfgc_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [vfgc_pkg::ADDR_W-1:0] frame_ram_addr,
  output logic frame_ram_write_enable,
  output logic frame_ram_output_enable,
  output logic converter_buffer_enable,
  output logic addr_count_enable,
  output logic vsync_detected
);
  localparam int FRAME_N = FRAME_SAMPLES;

  // Refuse a frame that the 18-bit address cannot span
  if (FRAME_SAMPLES < 2 ||
      FRAME_SAMPLES > 2 ** vfgc_pkg::ADDR_W) begin : g_bad_frame
    $error("frame length outside the RAM address range");
  end

  vfgc_link_if link ();

  // Pin synchronisers; the first stage feeds only the second
  logic [vfgc_pkg::SAMPLE_W-1:0] vid_meta;
  logic [vfgc_pkg::SAMPLE_W-1:0] vid_sync;
  logic btn_meta;
  logic btn_sync;

  always_ff @(posedge mclk) begin
    vid_meta <= video_sample;
    vid_sync <= vid_meta;
    btn_meta <= capture_button;
    btn_sync <= btn_meta;
  end

  assign link.sample = vid_sync;

  vfgc_sync_det u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .link (link)
  );

  vfgc_addr_ctr #(
    .FRAME_SAMPLES (FRAME_SAMPLES)
  ) u_addr (
    .mclk (mclk),
    .rstn (rstn),
    .link (link)
  );

  // Software hold acts like the button, for remote operation
  logic ctrl_hold;
  wire hold = btn_sync || ctrl_hold;

  vfgc_pkg::vfgc_state_t state;
  vfgc_pkg::vfgc_state_t next_state;

  // Hold wins over every other event, so a press always aborts capture
  always_comb begin
    next_state = state;
    case (state)
      vfgc_pkg::VFGC_PASS: begin
        if (!hold) begin
          next_state = vfgc_pkg::VFGC_WAIT_VS;
        end
      end
      vfgc_pkg::VFGC_WAIT_VS: begin
        if (hold) begin
          next_state = vfgc_pkg::VFGC_PASS;
        end else if (link.vsync) begin
          next_state = vfgc_pkg::VFGC_SAMPLE;
        end
      end
      vfgc_pkg::VFGC_SAMPLE: begin
        if (hold) begin
          next_state = vfgc_pkg::VFGC_PASS;
        end else if (link.frame_end) begin
          next_state = vfgc_pkg::VFGC_REPLAY;
        end
      end
      vfgc_pkg::VFGC_REPLAY: begin
        if (hold) begin
          next_state = vfgc_pkg::VFGC_PASS;
        end
      end
      default: begin
        next_state = vfgc_pkg::VFGC_PASS;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= vfgc_pkg::VFGC_PASS;
    end else begin
      state <= next_state;
    end
  end

  // RAM controls decoded straight from the state register
  wire in_sample = (state == vfgc_pkg::VFGC_SAMPLE);
  wire in_replay = (state == vfgc_pkg::VFGC_REPLAY);

  assign frame_ram_write_enable = in_sample;
  assign frame_ram_output_enable = in_replay;
  assign converter_buffer_enable = !in_replay;
  assign addr_count_enable = in_sample || in_replay;
  assign link.count_enable = addr_count_enable;
  assign frame_ram_addr = link.addr;
  assign vsync_detected = link.vsync;

  // Completed captures, for software to notice a fresh frame
  logic [vfgc_pkg::FRAMES_W-1:0] frames_done;
  wire capture_done = in_sample && link.frame_end && !hold;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      frames_done <= '0;
    end else if (capture_done) begin
      frames_done <= frames_done + 1'b1;
    end
  end

  // One offset decode shared by every register
  function automatic logic reg_hit(
    input logic [vfgc_pkg::PADDR_W-1:0] addr,
    input logic [vfgc_pkg::PADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction

  // APB slave, zero wait states; read data latched in setup phase
  wire apb_setup = psel && !penable;
  wire apb_access = psel && penable;
  wire hit_ctrl = reg_hit(paddr, vfgc_pkg::REG_CTRL);
  wire hit_status = reg_hit(paddr, vfgc_pkg::REG_STATUS);
  wire hit_addr = reg_hit(paddr, vfgc_pkg::REG_ADDR);
  wire hit_frames = reg_hit(paddr, vfgc_pkg::REG_FRAMES);
  wire hit_any = hit_ctrl || hit_status || hit_addr || hit_frames;
  wire ctrl_write = apb_access && pwrite && hit_ctrl;

  wire [31:0] status_word = {26'h0, frame_ram_output_enable,
    frame_ram_write_enable, btn_sync, link.vsync, state};
  wire [31:0] read_word =
    hit_ctrl ? {31'h0, ctrl_hold} :
    hit_status ? status_word :
    hit_addr ? {14'h0, link.addr} :
    hit_frames ? {16'h0, frames_done} : 32'h0;

  assign pready = 1'b1;
  assign pslverr = apb_access && !hit_any;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prdata <= 32'h0;
      ctrl_hold <= vfgc_pkg::CTRL_HOLD_RST;
    end else begin
      if (apb_setup && !pwrite) begin
        prdata <= read_word;
      end
      if (ctrl_write) begin
        ctrl_hold <= pwdata[vfgc_pkg::CTRL_HOLD_BIT];
      end
    end
  end

  // Helper for the checks below: length of the current write run
  logic [vfgc_pkg::ADDR_W:0] write_run;

  always_ff @(posedge mclk) begin
    if (!rstn || !frame_ram_write_enable) begin
      write_run <= '0;
    end else begin
      write_run <= write_run + 1'b1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_waiting;
    state == vfgc_pkg::VFGC_WAIT_VS && !hold;
  endsequence

  sequence s_capture_start;
    s_waiting ##0 link.vsync ##1 in_sample && link.addr == 18'h0;
  endsequence

  sequence s_frame_close;
    in_sample && link.frame_end && !hold
      ##1 in_replay && frame_ram_output_enable
      ##1 link.addr == 18'h1;
  endsequence

  a_reset_state: assert property (
    disable iff (1'b0)
    !rstn |=> state == vfgc_pkg::VFGC_PASS && !frame_ram_write_enable
      && !frame_ram_output_enable)
    else $error("reset did not return to pass-through");
  a_hold_passthru: assert property (
    hold |=> converter_buffer_enable && !frame_ram_write_enable
      && !frame_ram_output_enable)
    else $error("held button did not force pass-through");
  a_wait_for_vs: assert property (
    s_waiting ##0 !link.vsync |=> !frame_ram_write_enable)
    else $error("capture started without vertical sync");
  a_capture_start: assert property (
    s_waiting ##0 link.vsync |-> s_capture_start)
    else $error("capture did not start after vertical sync");
  a_write_from_vs: assert property (
    $rose(frame_ram_write_enable) |-> $past(link.vsync))
    else $error("write enable rose without vsync");
  a_write_span: assert property (
    $fell(frame_ram_write_enable) && in_replay |-> write_run == FRAME_N)
    else $error("frame capture length wrong");
  a_frame_close: assert property (
    in_sample && link.frame_end && !hold |-> s_frame_close)
    else $error("no switch to read at final sample");
  a_replay_cycles: assert property (
    in_replay && !hold && !link.frame_end |=>
      in_replay && link.addr == $past(link.addr) + 18'h1)
    else $error("replay address did not step each clock");
  a_bus_exclusive: assert property (
    !(frame_ram_output_enable &&
      (converter_buffer_enable || frame_ram_write_enable)))
    else $error("RAM and converter drive the bus together");
  a_sample_stream: assert property (
    link.sample == $past(video_sample, 2))
    else $error("sample path delay is not two clocks");

  // Reset checks run with the usual disable switched off
  a_reset_counters: assert property (
    disable iff (1'b0)
    !rstn |=> link.addr == 18'h0 && link.sync_count == 7'h00)
    else $error("reset did not clear the counters");

  // Capture sequencing
  a_pass_stays: assert property (
    state == vfgc_pkg::VFGC_PASS && hold |=> state == vfgc_pkg::VFGC_PASS)
    else $error("pass-through left while hold is active");
  a_arm_on_release: assert property (
    state == vfgc_pkg::VFGC_PASS && !hold |=>
      state == vfgc_pkg::VFGC_WAIT_VS)
    else $error("release did not arm a capture");
  a_wait_no_read: assert property (
    state == vfgc_pkg::VFGC_WAIT_VS |->
      !frame_ram_output_enable && converter_buffer_enable)
    else $error("RAM on the bus while waiting for sync");
  a_write_run_cap: assert property (
    frame_ram_write_enable |-> write_run < FRAME_N)
    else $error("write run longer than one frame");
  a_vsync_pulse: assert property (
    link.vsync |=> !link.vsync)
    else $error("vsync held longer than one clock");

  // Replay and register side
  a_live_until_replay: assert property (
    $fell(converter_buffer_enable) |-> $past(in_sample) && in_replay)
    else $error("converter buffer dropped outside the replay switch");
  a_replay_wrap: assert property (
    in_replay && link.frame_end && !hold |=>
      in_replay && link.addr == 18'h0)
    else $error("replay did not wrap to the first sample");
  a_frames_step: assert property (
    capture_done |=> frames_done == $past(frames_done) + 16'h1)
    else $error("completed capture not counted");
  a_ctrl_write: assert property (
    ctrl_write |=> ctrl_hold == $past(pwdata[vfgc_pkg::CTRL_HOLD_BIT]))
    else $error("control write did not land");
endmodule

// ### test/vfgc_video_src.sv
/*
  Stand-in for the video converter: one sample per clock.
  Assumes the bench selects a sync-level run with zero_run.
*/
`timescale 1ns/1ps
module vfgc_video_src (
  input wire logic mclk,
  input wire logic zero_run,
  output logic [vfgc_pkg::SAMPLE_W-1:0] sample
);
  logic [7:0] ramp = 8'h01;
  // Never zero outside a run, so no false sync
  always_ff @(posedge mclk) begin
    ramp <= (ramp == 8'hff) ? 8'h01 : ramp + 8'h01;
  end
  assign sample = zero_run ? 8'h00 : ramp;
endmodule

// ### test/vfgc_top_tb_top.sv
/*
  Self-checking bench for the frame grabber controller over APB.
  Assumes zero wait states are not relied on and a short frame length.
*/
`timescale 1ns/1ps
module vfgc_top_tb_top;
  localparam int FS = 20;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic zero_run = 1'b0;
  logic capture_button = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [vfgc_pkg::SAMPLE_W-1:0] video_sample;
  logic [vfgc_pkg::ADDR_W-1:0] ram_addr;
  logic we;
  logic oe;
  logic buf_en;
  logic cnt_en;
  logic vsync;
  logic [31:0] q;
  logic e;
  int err_count = 0;
  int comparisons = 0;
  int n;
  always #50 mclk = ~mclk;
  vfgc_video_src src (.mclk(mclk), .zero_run(zero_run),
    .sample(video_sample));
  vfgc_top #(.FRAME_SAMPLES(FS)) dut (.mclk(mclk), .rstn(rstn),
    .video_sample(video_sample), .capture_button(capture_button),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_ram_addr(ram_addr),
    .frame_ram_write_enable(we), .frame_ram_output_enable(oe),
    .converter_buffer_enable(buf_en), .addr_count_enable(cnt_en),
    .vsync_detected(vsync));
  task summarize;
    begin
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  task bound(input int cnt, input int lim);
    begin
      if (cnt >= lim) begin
        $display("MISMATCH wait expected <%0d seen %0d", lim, cnt);
        err_count++;
        summarize();
      end
    end
  endtask
  task chk1(input string nm, input logic exp, input logic got);
    begin
      comparisons++;
      if (got !== exp) begin
        $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        err_count++;
      end
    end
  endtask
  task chk32(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    begin
      comparisons++;
      if (got !== exp) begin
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        err_count++;
      end
    end
  endtask
  // Called just after a rising edge; returns one edge after release,
  // so two calls never drive psel twice in one time step
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (pready !== 1'b1 && k < 50);
      bound(k, 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task cycles(input int c);
    repeat (c) @(posedge mclk);
  endtask
  initial begin
    cycles(12);
    rstn <= 1'b1;
    cycles(4);
    apb(1'b0, vfgc_pkg::REG_STATUS, 32'h0);
    chk32("status", 32'h1, q & 32'h33);
    chk1("buf_en", 1'b1, buf_en);
    chk32("addr", 32'h0, 32'(ram_addr));
    chk1("pready", 1'b1, pready);
    apb(1'b0, 8'h10, 32'h0);
    chk1("pslverr", 1'b1, e);
    chk32("unmapped", 32'h0, q);
    apb(1'b1, vfgc_pkg::REG_CTRL, 32'h1);
    cycles(2);
    apb(1'b0, vfgc_pkg::REG_STATUS, 32'h0);
    chk32("hold_state", 32'h0, q & 32'h3);
    apb(1'b0, vfgc_pkg::REG_CTRL, 32'h0);
    chk32("ctrl", 32'h1, q);
    apb(1'b1, vfgc_pkg::REG_CTRL, 32'h0);
    capture_button <= 1'b1;
    cycles(5);
    apb(1'b0, vfgc_pkg::REG_STATUS, 32'h0);
    chk32("button_state", 32'h8, q & 32'h3f);
    chk1("pass_buf", 1'b1, buf_en);
    capture_button <= 1'b0;
    zero_run <= 1'b1;
    for (n = 0; n < 110; n++) begin
      @(negedge mclk);
      chk1("short_run", 1'b0, vsync | we);
    end
    @(posedge mclk);
    zero_run <= 1'b0;
    cycles(3);
    zero_run <= 1'b1;
    n = 0;
    while (vsync !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    bound(n, 200);
    chk1("vs_time", 1'b1, n >= 127 && n <= 134);
    while (we !== 1'b1 && n < 210) begin
      @(negedge mclk);
      n++;
    end
    bound(n, 210);
    for (n = 0; n < FS; n++) begin
      chk1("we", 1'b1, we & cnt_en & buf_en & ~oe);
      chk32("wr_addr", 32'(n), 32'(ram_addr));
      @(negedge mclk);
    end
    chk1("rd_oe", 1'b1, oe & ~we & ~buf_en);
    for (n = 0; n < 2 * FS + 3; n++) begin
      chk32("rd_addr", 32'(n % FS), 32'(ram_addr));
      @(negedge mclk);
    end
    @(posedge mclk);
    zero_run <= 1'b0;
    apb(1'b0, vfgc_pkg::REG_FRAMES, 32'h0);
    chk32("frames", 32'h1, q);
    capture_button <= 1'b1;
    cycles(5);
    @(negedge mclk);
    chk1("again_oe", 1'b0, oe | we);
    chk1("again_buf", 1'b1, buf_en);
    chk32("again_addr", 32'h0, 32'(ram_addr));
    @(posedge mclk);
    apb(1'b0, vfgc_pkg::REG_ADDR, 32'h0);
    chk32("addr_reg", 32'h0, q);
    summarize();
  end
endmodule
